// File: core/qbg_pkg.sv
/*
  Package for the quasi-bidirectional GPIO port: register offsets, field
  positions, reset values and the status and event register fields.
  Assumes a 32-bit APB with byte addressing, word-aligned registers.
*/
package qbg_pkg;
  // Printed offsets are not all multiples of four: they are indices
  localparam logic [7:0] QBG_IDX_PIN_CFG = 8'h12;
  localparam logic [7:0] QBG_IDX_PORT_DATA = 8'h7a;
  // Byte addresses are four times the index
  localparam logic [11:0] QBG_ADDR_PIN_CFG = {2'h0, QBG_IDX_PIN_CFG, 2'h0};
  localparam logic [11:0] QBG_ADDR_PORT_DATA = {2'h0, QBG_IDX_PORT_DATA, 2'h0};
  // Extra registers for status and event controls
  localparam logic [11:0] QBG_ADDR_STATUS = 12'h200;
  localparam logic [11:0] QBG_ADDR_EVENT = 12'h204;
  // Alternate-function bit positions in the pin configuration register
  localparam int QBG_CFG_ALARM_IN = 0;
  localparam int QBG_CFG_ALARM_OUT = 1;
  localparam int QBG_CFG_TRIGGER = 2;
  localparam int QBG_CFG_READY = 3;
  localparam int QBG_ALT_PINS = 4;
  localparam int QBG_PINS = 8;
  // Reset values
  localparam logic [7:0] QBG_DATA_RESET = 8'hff;
  localparam logic [7:0] QBG_CFG_RESET = 8'h00;
  // Status register fields
  localparam int QBG_ST_READY = 0;
  localparam int QBG_ST_CLEAR = 1;
  localparam int QBG_ST_ALARM = 2;
  // Event register write fields
  localparam int QBG_EV_DONE = 0;
  localparam int QBG_EV_START = 1;
  localparam int QBG_EV_DATA_ACC = 2;
endpackage : qbg_pkg

// File: core/qbg_sync.sv
/*
  Two-flop synchroniser for a vector of pin levels.
  Assumes inputs are asynchronous to pclk; output is two flops deep.
*/
`timescale 1ns/10ps
`default_nettype none
module qbg_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // Both stages in one struct, first stage read only by the second
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } qbg_sync_state_t;

  qbg_sync_state_t st_r;
  qbg_sync_state_t st_nxt;

  // Shift the pin levels through the two stages
  always_comb begin
    st_nxt.meta = async_in;
    st_nxt.stable = st_r.meta;
  end

  // Released pins idle high through the pull-ups, so reset to ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= {INIT, INIT};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stable;
endmodule : qbg_sync
`default_nettype wire

// File: core/qbg_port.sv
/*
  Eight-pin quasi-bidirectional GPIO port with an APB register slave.
  Pins 0..3 may carry alternate functions: DAC clear alarm input, global
  alarm output, external conversion trigger, conversion data ready.
  Assumes: external pull-ups on every pin; pad logic resolves each pin
  from its output enable; converter and alarm logic sit on pclk.
*/
// The APB register port was left to the implementer.
//
// Summary of operation
// - Pins 0-3 selectable as GPIO or alternate
// - Pins 4-7 always plain GPIO
// - Pin 0 alternate: alarm input clears DACs
// - Pin 2 alternate: external conversion trigger input
// - Pin 3 alternate: conversion data ready output
// - Output pin follows its data bit
// - Input read returns the pin level; pins in alternate mode read back their data bit instead
// - Reset sets all data bits to 1
// - Alarm input is active low
// - Alarm output signals unmasked alarms
// - Ready low on done, cleared on start/access
`timescale 1ns/10ps
`default_nettype none
module qbg_port
  import qbg_pkg::*;
#(
  parameter int PINS = QBG_PINS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe,
  input wire logic alarm_event,
  input wire logic conv_done,
  input wire logic conv_start,
  input wire logic data_reg_access,
  output logic dac_clear_alarm_input,
  output logic external_conversion_trigger
);
  // Whole module state
  typedef struct packed {
    logic [PINS-1:0] port_data;      // Data register
    logic [7:0] pin_function_config; // Alternate selects in low nibble
    logic ready_flag;                // Conversion data ready, active high
    logic trig_prev;                 // Last synced trigger pin level
    logic [PINS-1:0] pin_out;
    logic [PINS-1:0] pin_oe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic dac_clear;
    logic trigger;
  } qbg_state_t;

  qbg_state_t st_r;
  qbg_state_t st_nxt;
  logic [PINS-1:0] pin_sync;         // Synchronised pin levels

  // Pin levels pass two flops before any logic looks at them
  // Costs two cycles of input latency but keeps metastability off the logic
  qbg_sync #(
    .WIDTH(PINS),
    .INIT({PINS{1'b1}})
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // Alternate-function select for one pin, upper pins never selectable
  function automatic logic alt_sel(input logic [7:0] cfg, input int idx);
    logic sel;
    sel = 1'b0;
    if (idx < QBG_ALT_PINS) begin
      sel = cfg[idx];
    end
    return sel;
  endfunction : alt_sel

  // Register access, event flags and pin drive
  always_comb begin
    logic access;
    logic wr;
    logic rd;
    logic hit;
    logic [PINS-1:0] rd_data;
    logic alarm_drive;
    logic ready_drive;
    // Take the access phase once; pready high blocks a second take
    access = psel && penable && !st_r.pready;
    wr = access && pwrite && pstrb[0];
    rd = access && !pwrite;
    hit = 1'b1;
    rd_data = '0;
    alarm_drive = 1'b0;
    ready_drive = 1'b0;
    st_nxt = st_r;
    st_nxt.pready = access;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata = '0;
    st_nxt.trig_prev = pin_sync[QBG_CFG_TRIGGER];

    // GPIO pins read back the pin level; pins in alternate mode read back their data bit
    for (int i = 0; i < PINS; i++) begin
      rd_data[i] = alt_sel(st_r.pin_function_config, i) ? st_r.port_data[i] : pin_sync[i];
    end

    // Address decode; unmapped addresses answer with an error
    case (paddr)
      QBG_ADDR_PIN_CFG: begin
        st_nxt.prdata[7:0] = st_r.pin_function_config;
        if (wr) begin
          st_nxt.pin_function_config = {4'h0, pwdata[3:0]};
        end
      end
      QBG_ADDR_PORT_DATA: begin
        st_nxt.prdata[PINS-1:0] = rd_data;
        if (wr) begin
          st_nxt.port_data = pwdata[PINS-1:0];
        end
      end
      QBG_ADDR_STATUS: begin
        // Read-only view of the flags; writes are accepted and ignored
        st_nxt.prdata[QBG_ST_READY] = st_r.ready_flag;
        st_nxt.prdata[QBG_ST_CLEAR] = st_r.dac_clear;
        st_nxt.prdata[QBG_ST_ALARM] = alarm_event;
      end
      QBG_ADDR_EVENT: begin
        // Write-only pulses for the ready flag; reads return zero
        st_nxt.prdata = '0;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (access && !hit) begin
      st_nxt.pslverr = 1'b1;
    end

    // Read data stands only in the answer cycle, zero otherwise
    if (!rd) begin
      st_nxt.prdata = '0;
    end

    // clear on start or data access, set on done (set wins)
    if (conv_start || data_reg_access ||
        (wr && hit && paddr == QBG_ADDR_EVENT &&
         (pwdata[QBG_EV_START] || pwdata[QBG_EV_DATA_ACC]))) begin
      st_nxt.ready_flag = 1'b0;
    end
    if (conv_done || (wr && paddr == QBG_ADDR_EVENT && pwdata[QBG_EV_DONE])) begin
      st_nxt.ready_flag = 1'b1;
    end

    // low level on pin 0 clears DACs
    st_nxt.dac_clear = alt_sel(st_r.pin_function_config, QBG_CFG_ALARM_IN) &&
                       !pin_sync[QBG_CFG_ALARM_IN];
    // falling edge on pin 2 starts a conversion
    st_nxt.trigger = alt_sel(st_r.pin_function_config, QBG_CFG_TRIGGER) &&
                     st_r.trig_prev && !pin_sync[QBG_CFG_TRIGGER];

    // unmasked alarm pulls pin 1 low
    // Masking happens upstream on pclk, so no synchroniser here
    alarm_drive = alarm_event;
    // ready pin low while data is available
    ready_drive = st_nxt.ready_flag;

    // Drive is taken from the next state so pins move with the write
    for (int i = 0; i < PINS; i++) begin
      st_nxt.pin_out[i] = 1'b0;
      st_nxt.pin_oe[i] = !st_nxt.port_data[i];
      if (alt_sel(st_nxt.pin_function_config, i)) begin
        if (i == QBG_CFG_ALARM_OUT) begin
          st_nxt.pin_oe[i] = alarm_drive;
        end else if (i == QBG_CFG_READY) begin
          st_nxt.pin_oe[i] = ready_drive;
        end else begin
          // Inputs in alternate mode stay released
          st_nxt.pin_oe[i] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{port_data: QBG_DATA_RESET[PINS-1:0], pin_function_config: QBG_CFG_RESET,
                ready_flag: 1'b0, trig_prev: 1'b1, pin_out: '0, pin_oe: '0,
                prdata: '0, pready: 1'b0, pslverr: 1'b0, dac_clear: 1'b0,
                trigger: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign pin_out = st_r.pin_out;
  assign pin_oe = st_r.pin_oe;
  assign dac_clear_alarm_input = st_r.dac_clear;
  assign external_conversion_trigger = st_r.trigger;
endmodule : qbg_port
`default_nettype wire

// File: verif/qbg_port_checker.sv
/* Assertions on the GPIO port pins and the DAC clear and trigger outputs.
   Assumes binding into qbg_port with the one-wait-state APB slave. */
`timescale 1ns/10ps
`default_nettype none
module qbg_port_checker
  import qbg_pkg::*;
#(
  parameter int PINS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe,
  input wire logic alarm_event,
  input wire logic conv_done,
  input wire logic conv_start,
  input wire logic data_reg_access,
  input wire logic dac_clear_alarm_input,
  input wire logic external_conversion_trigger
);
  // Completed write, seen at the edge the master sees pready
  wire logic wr = psel && penable && pready && pwrite && !pslverr;
  // Access phase taken by the slave: the edge at which a write lands
  wire logic take = psel && penable && !pready;
  logic [3:0] cfg_r; // Shadow of the function selects
  // Shadow tracks bus writes so alternate checks know the mode
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) cfg_r <= 4'h0;
    else if (take && pwrite && pstrb[0] && paddr == QBG_ADDR_PIN_CFG) cfg_r <= pwdata[3:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  drive_zero_a: assert property (pin_out == '0) else $error("pin drive not low");
  hi_follow_a: assert property (wr && paddr == QBG_ADDR_PORT_DATA && pstrb[0]
    |=> pin_oe[7:4] == ~$past(pwdata[7:4])) else $error("upper pins wrong");
  hi_hold_a: assert property (!(take && pwrite && pstrb[0] && paddr == QBG_ADDR_PORT_DATA)
    |=> $stable(pin_oe[7:4])) else $error("upper pins moved");
  alt_own_a: assert property (cfg_r[0] |-> !pin_oe[0]) else $error("pin0 driven");
  clr_cause_a: assert property (dac_clear_alarm_input |-> $past(cfg_r[0])) else $error("clear");
  alarm_out_a: assert property (cfg_r[1] && $past(cfg_r[1])
    |-> pin_oe[1] == $past(alarm_event)) else $error("alarm pin wrong");
  trig_pulse_a: assert property (external_conversion_trigger
    |=> !external_conversion_trigger) else $error("trigger too long");
  ready_set_a: assert property (cfg_r[3] && conv_done |=> pin_oe[3]) else $error("ready");
  ready_clr_a: assert property (cfg_r[3] && !conv_done && (conv_start || data_reg_access)
    |=> !pin_oe[3]) else $error("ready not cleared");
  cover property (external_conversion_trigger);
  cover property (dac_clear_alarm_input);
  cover property (pslverr);
endmodule : qbg_port_checker
bind qbg_port qbg_port_checker #(.PINS(PINS)) u_chk (.*);
`default_nettype wire

// File: verif/qbg_board.sv
/* Board side of the eight pins: pull-ups and outside pull-down drivers.
   Assumes the port only ever pulls a pin low. */
`timescale 1ns/10ps
`default_nettype none
module qbg_board (
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_low,
  output logic [7:0] pin_lvl
);
  assign pin_lvl = ~(pin_oe | ext_low);
endmodule : qbg_board
`default_nettype wire

// File: verif/tb_qbg_port.sv
/* Self-checking bench for the GPIO port.
   Assumes qbg_pkg, qbg_port and the board model are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb_qbg_port
  import qbg_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, dac_clear_alarm_input, external_conversion_trigger;
  logic alarm_event = 0, conv_done = 0, conv_start = 0, data_reg_access = 0;
  logic [7:0] pin_in, pin_out, pin_oe, ext = 8'h00, d;
  integer seed = 32'he60b, error_cnt = 0, comparisons = 0, cyc = 0, n, i;
  qbg_port u_dut (.*);
  qbg_board u_brd (.pin_oe(pin_oe), .ext_low(ext), .pin_lvl(pin_in));
  initial forever #50 pclk = ~pclk;
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      give_verdict;
    end
  end
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", s, e, g);
      error_cnt++;
    end
  endtask : chk
  // One APB transfer; waits for the answer, no assumed latency
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(negedge pclk);
  endtask : apb
  task give_verdict;
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(negedge pclk);
    chk("oe", 0, pin_oe);
    apb(0, QBG_ADDR_PORT_DATA, 0);
    chk("data", 32'hff, rd);
    apb(0, 12'h004, 0);
    chk("err", 1, er);
    // Random levels; ones release pins for input use
    for (i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      @(posedge pclk);
      ext <= 8'($random(seed));
      apb(1, QBG_ADDR_PORT_DATA, {24'h0, d});
      chk("oe", d ^ 8'hff, pin_oe);
      apb(0, QBG_ADDR_PORT_DATA, 0);
      chk("rd", d & ~ext, rd);
    end
    @(posedge pclk);
    ext <= 8'h00;
    apb(1, QBG_ADDR_PORT_DATA, 0);
    apb(1, QBG_ADDR_PIN_CFG, 32'hff);
    apb(0, QBG_ADDR_PIN_CFG, 0);
    chk("cfg", 32'h0f, rd);
    chk("oe", 32'hf0, pin_oe);
    @(posedge pclk);
    ext <= 8'h01;
    repeat (5) @(negedge pclk);
    chk("clr", 1, dac_clear_alarm_input);
    @(posedge pclk);
    ext <= 8'h04;
    n = 0;
    repeat (8) begin
      @(negedge pclk);
      n += external_conversion_trigger;
    end
    chk("trig", 1, n);
    chk("clr", 0, dac_clear_alarm_input);
    @(posedge pclk);
    alarm_event <= 1;
    repeat (2) @(negedge pclk);
    chk("alm", 1, pin_oe[1]);
    for (i = 0; i < 2; i++) begin
      @(posedge pclk);
      conv_done <= 1;
      @(posedge pclk);
      conv_done <= 0;
      @(negedge pclk);
      chk("rdy", 1, pin_oe[3]);
      @(posedge pclk);
      {conv_start, data_reg_access} <= 2'b01 << i;
      @(posedge pclk);
      {conv_start, data_reg_access} <= 2'b00;
      @(negedge pclk);
      chk("rdy", 0, pin_oe[3]);
    end
    // Status view and software event pulses; set wins over clear
    apb(0, QBG_ADDR_STATUS, 0);
    chk("st", 32'h1 << QBG_ST_ALARM, rd);
    apb(1, QBG_ADDR_EVENT, (32'h1 << QBG_EV_DONE) | (32'h1 << QBG_EV_START));
    chk("rdy", 1, pin_oe[3]);
    apb(0, QBG_ADDR_STATUS, 0);
    chk("st", (32'h1 << QBG_ST_ALARM) | (32'h1 << QBG_ST_READY), rd);
    apb(1, QBG_ADDR_EVENT, 32'h1 << QBG_EV_DATA_ACC);
    chk("rdy", 0, pin_oe[3]);
    apb(0, QBG_ADDR_EVENT, 0);
    chk("ev", 0, rd);
    // Writes with the low byte lane off are ignored
    @(posedge pclk);
    pstrb <= 4'he;
    apb(1, QBG_ADDR_PORT_DATA, 32'hff);
    chk("oe", 32'hf, pin_oe[7:4]);
    @(posedge pclk);
    pstrb <= 4'hf;
    // Forced reset in mid-run releases every pin again
    ext <= 8'h00;
    alarm_event <= 0;
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(negedge pclk);
    chk("oe", 0, pin_oe);
    apb(0, QBG_ADDR_PIN_CFG, 0);
    chk("cfg", {24'h0, QBG_CFG_RESET}, rd);
    apb(0, QBG_ADDR_PORT_DATA, 0);
    chk("data", {24'h0, QBG_DATA_RESET}, rd);
    give_verdict;
  end
endmodule : tb_qbg_port
`default_nettype wire
